// ===== inv_ctrl_pkg.sv
// Constants and carrier types for the inverter control-source block.
// Assumes an APB master with 32-bit data and one clock at 200 MHz.
package inv_ctrl_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL_SRC = 8'h00;
  localparam logic [7:0] OFS_DSET_SEL = 8'h04;
  localparam logic [7:0] OFS_ACT_DSET = 8'h08;
  localparam logic [7:0] OFS_CONFIG = 8'h0C;
  localparam logic [7:0] OFS_CTRL_WORD = 8'h10;
  localparam logic [7:0] OFS_STAT_WORD = 8'h14;
  localparam logic [7:0] OFS_WARN_STAT = 8'h18;
  localparam logic [7:0] OFS_OP_MODE = 8'h1C;

  // Control-source encodings
  localparam logic [1:0] SRC_INPUTS = 2'h0;
  localparam logic [1:0] SRC_STATE_MACHINE = 2'h1;
  localparam logic [1:0] SRC_EMULATED = 2'h2;

  // Data-set selection limits, reset values and mode encodings
  localparam logic [2:0] DSET_BY_INPUTS = 3'h0;
  localparam logic [2:0] DSET_MAX = 3'h4;
  localparam logic [1:0] RST_CTRL_SRC = 2'h0;
  localparam logic [2:0] RST_DSET_SEL = 3'h0;
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] CFG_MOTION = 8'h40;
  localparam logic [7:0] RST_OP_MODE = 8'h02;
  localparam logic [7:0] OP_MODE_VELOCITY = 8'h02;

  // Control-word bit positions
  localparam int CW_SWITCH_ON = 0;
  localparam int CW_ENABLE_VOLT = 1;
  localparam int CW_QUICK_STOP_N = 2;
  localparam int CW_ENABLE_OP = 3;
  localparam int CW_FAULT_RESET = 7;
  localparam int CW_HALT = 8;
  localparam int CW_UNUSED = 14;

  // Status-word bit positions
  localparam int SW_FAULT = 3;
  localparam int SW_VOLTAGE = 4;
  localparam int SW_WARNING = 7;
  localparam int SW_REMOTE = 9;
  localparam int SW_TARGET = 10;
  localparam int SW_LIMIT = 11;
  localparam int SW_WARNING2 = 15;

  // Low six status bits in the input-driven modes
  localparam logic [5:0] IN_SW_SWITCHED_ON = 6'h23;
  localparam logic [5:0] IN_SW_OP_ENABLED = 6'h37;

  // Pins from the power stage and terminals, all asynchronous to pclk
  typedef struct packed {
    logic torque_off_channel_a;
    logic torque_off_channel_b;
    logic start_cw_input;
    logic start_ccw_input;
    logic [1:0] dset_inputs;
    logic mains_present;
    logic fault_active;
    logic ref_reached;
    logic pfail_zero_hz;
    logic limit_active;
    logic [1:0] mode_status;
    logic [7:0] warn_causes;
    logic [3:0] prewarn_causes;
  } drive_pins_t;

  // Commands to the drive
  typedef struct packed {
    logic run;
    logic dir_ccw;
    logic quick_stop;
    logic [3:0] motion_bits;
    logic [5:0] app_bits;
  } drive_cmd_t;

endpackage

// ===== inv_ctrl.sv
// Control-source selection, device state machine and status word of an inverter.
// Assumes an APB master on pclk; all drive_pins fields are asynchronous pins.
//
// Contract
// - Source 0 hardware inputs, 1 control-word state machine, 2 emulated inputs.
// - Selection 0 takes data set from inputs; 1..4 forces that data set.
// - Active data set reads back as 1..4 whatever chose it.
// - Emulated mode starts only with both torque-off channels and control bit 0.
// - Input-driven modes act only in velocity operating mode.
// - In input modes status bit 4 shows mains; no mains blocks start.
// - Input modes report 100011 switched on, 110111 enabled, bit 3 fault.
// - Status bit 7 flags any warning; cause readable in warning register.
// - Status bit 10 on reference reached or power-fail brought to 0 Hz.
// - Status bit 11 while an internal limit is active.
// - Status bit 15 on warnings that soon lead to fault shutdown.
// - Control word drives the state machine only while source is 1.
// - Enable operation needs safe enable; non-motion configs also a start input.
// - Bits 4,5,6,8 used only in motion config; bit 14 ignored.
// - Status bits 12 and 13 driven only in motion configuration.
// - Without mains, ready to switch on cannot become switched on.
// - Commands from bits 0..3 and 7; 0x0F enables; bit 7 rise resets fault.
// - Losing safe enable in operation enabled falls back to switched on.
// - Status bit 9 only with state-machine source and hardware enable.
//
// Decided for this implementation: register access over APB and the register offsets.
module inv_ctrl
  import inv_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Drive pins
  input wire drive_pins_t drive_pins,
  // Drive commands
  output drive_cmd_t drive_cmd,
  output logic [2:0] active_dset
);

  typedef enum logic [5:0] {
    ST_SW_DISABLED = 6'h01,
    ST_READY = 6'h02,
    ST_SWITCHED_ON = 6'h04,
    ST_OP_ENABLED = 6'h08,
    ST_QUICK_STOP = 6'h10,
    ST_FAULT = 6'h20
  } dev_state_t;

  drive_pins_t pins_meta;
  drive_pins_t pins;
  logic [1:0] ctrl_src;
  logic [2:0] dset_sel;
  logic [7:0] config_val;
  logic [7:0] op_mode;
  logic [15:0] ctrl_word;
  logic [15:0] status_word;
  logic [15:0] next_status;
  logic fault_reset_prev;
  dev_state_t state;
  dev_state_t next_state;
  logic safe_enable;
  logic motion_cfg;
  logic velocity_mode;
  logic fault_reset_edge;
  logic in_start_ok;
  logic in_run;
  logic in_dir_ccw;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [31:0] rd_mux;

  // Two-flop synchroniser for every pin
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pins_meta <= '0;
      pins <= '0;
    end
    else
    begin
      pins_meta <= drive_pins;
      pins <= pins_meta;
    end
  end

  assign safe_enable = pins.torque_off_channel_a & pins.torque_off_channel_b;
  assign motion_cfg = (config_val == CFG_MOTION);
  assign velocity_mode = (op_mode == OP_MODE_VELOCITY);

  // APB: one wait state, write lands at the completing edge
  assign wr_en = psel & penable & pready & pwrite;
  assign rd_en = psel & penable & ~pready & ~pwrite;

  always_comb
  begin
    addr_ok = 1'b1;
    rd_mux = '0;
    unique case (paddr)
      OFS_CTRL_SRC: rd_mux = {30'h0, ctrl_src};
      OFS_DSET_SEL: rd_mux = {29'h0, dset_sel};
      OFS_ACT_DSET: rd_mux = {29'h0, active_dset};
      OFS_CONFIG: rd_mux = {24'h0, config_val};
      OFS_CTRL_WORD: rd_mux = {16'h0, ctrl_word};
      OFS_STAT_WORD: rd_mux = {16'h0, status_word};
      OFS_WARN_STAT: rd_mux = {20'h0, pins.prewarn_causes, pins.warn_causes};
      OFS_OP_MODE: rd_mux = {24'h0, op_mode};
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
    else
    begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~addr_ok;
      if (rd_en)
      begin
        prdata <= rd_mux;
      end
    end
  end

  // Writable settings
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_src <= RST_CTRL_SRC;
      dset_sel <= RST_DSET_SEL;
      config_val <= RST_CONFIG;
      op_mode <= RST_OP_MODE;
      ctrl_word <= '0;
    end
    else if (wr_en)
    begin
      if (paddr == OFS_CTRL_SRC && pwdata[31:0] <= 32'h2)
      begin
        ctrl_src <= pwdata[1:0];
      end
      if (paddr == OFS_DSET_SEL && pwdata[31:0] <= 32'h4)
      begin
        dset_sel <= pwdata[2:0];
      end
      if (paddr == OFS_CONFIG)
      begin
        config_val <= pwdata[7:0];
      end
      if (paddr == OFS_OP_MODE)
      begin
        op_mode <= pwdata[7:0];
      end
      if (paddr == OFS_CTRL_WORD)
      begin
        ctrl_word <= pwdata[15:0];
      end
    end
  end

  // Active data set: forced by selection or taken from the inputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      active_dset <= 3'h1;
    end
    else if (dset_sel != DSET_BY_INPUTS)
    begin
      active_dset <= dset_sel;
    end
    else
    begin
      active_dset <= {1'b0, pins.dset_inputs} + 3'h1;
    end
  end

  // Fault-reset edge on control-word bit 7
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fault_reset_prev <= 1'b0;
    end
    else
    begin
      fault_reset_prev <= ctrl_word[CW_FAULT_RESET];
    end
  end

  assign fault_reset_edge = ctrl_word[CW_FAULT_RESET] & ~fault_reset_prev;

  // Device state machine, stepped by the control word in source 1 only
  always_comb
  begin
    next_state = state;
    if (pins.fault_active)
    begin
      next_state = ST_FAULT;
    end
    else if (ctrl_src != SRC_STATE_MACHINE)
    begin
      next_state = ST_SW_DISABLED;
    end
    else
    begin
      unique case (state)
        ST_SW_DISABLED:
          if (ctrl_word[CW_ENABLE_VOLT] && ctrl_word[CW_QUICK_STOP_N]
              && !ctrl_word[CW_SWITCH_ON])
          begin
            next_state = ST_READY;
          end
        ST_READY:
          if (!ctrl_word[CW_ENABLE_VOLT] || !ctrl_word[CW_QUICK_STOP_N])
          begin
            next_state = ST_SW_DISABLED;
          end
          else if (ctrl_word[CW_SWITCH_ON] && pins.mains_present)
          begin
            next_state = ST_SWITCHED_ON;
          end
        ST_SWITCHED_ON:
          if (!ctrl_word[CW_ENABLE_VOLT] || !ctrl_word[CW_QUICK_STOP_N])
          begin
            next_state = ST_SW_DISABLED;
          end
          else if (!ctrl_word[CW_SWITCH_ON])
          begin
            next_state = ST_READY;
          end
          else if (ctrl_word[CW_ENABLE_OP] && safe_enable
                   && (motion_cfg || pins.start_cw_input || pins.start_ccw_input))
          begin
            next_state = ST_OP_ENABLED;
          end
        ST_OP_ENABLED:
          if (!ctrl_word[CW_ENABLE_VOLT])
          begin
            next_state = ST_SW_DISABLED;
          end
          else if (!ctrl_word[CW_QUICK_STOP_N])
          begin
            next_state = ST_QUICK_STOP;
          end
          else if (!ctrl_word[CW_SWITCH_ON])
          begin
            next_state = ST_READY;
          end
          else if (!ctrl_word[CW_ENABLE_OP] || !safe_enable)
          begin
            next_state = ST_SWITCHED_ON;
          end
        ST_QUICK_STOP:
          if (!ctrl_word[CW_ENABLE_VOLT])
          begin
            next_state = ST_SW_DISABLED;
          end
        ST_FAULT:
          if (fault_reset_edge)
          begin
            next_state = ST_SW_DISABLED;
          end
        default: next_state = ST_SW_DISABLED;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= ST_SW_DISABLED;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Input-driven start, real pins (0) or control-word emulation (2)
  always_comb
  begin
    in_start_ok = safe_enable & pins.mains_present & velocity_mode;
    in_run = 1'b0;
    in_dir_ccw = 1'b0;
    if (ctrl_src == SRC_INPUTS)
    begin
      in_run = in_start_ok & (pins.start_cw_input | pins.start_ccw_input);
      in_dir_ccw = pins.start_ccw_input & ~pins.start_cw_input;
    end
    else if (ctrl_src == SRC_EMULATED)
    begin
      in_run = in_start_ok & ctrl_word[CW_SWITCH_ON]
               & (ctrl_word[CW_ENABLE_VOLT] | ctrl_word[CW_QUICK_STOP_N]);
      in_dir_ccw = ctrl_word[CW_QUICK_STOP_N] & ~ctrl_word[CW_ENABLE_VOLT];
    end
    in_run = in_run & ~pins.fault_active;
  end

  // Drive commands
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      drive_cmd <= '0;
    end
    else
    begin
      if (ctrl_src == SRC_STATE_MACHINE)
      begin
        drive_cmd.run <= (state == ST_OP_ENABLED);
        drive_cmd.dir_ccw <= pins.start_ccw_input & ~pins.start_cw_input;
      end
      else
      begin
        drive_cmd.run <= in_run;
        drive_cmd.dir_ccw <= in_dir_ccw;
      end
      drive_cmd.quick_stop <= (state == ST_QUICK_STOP);
      drive_cmd.motion_bits <= motion_cfg ?
        {ctrl_word[CW_HALT], ctrl_word[6:4]} : 4'h0;
      drive_cmd.app_bits <= {ctrl_word[15], ctrl_word[13:9]};
    end
  end

  // Status word
  always_comb
  begin
    next_status = '0;
    if (ctrl_src == SRC_STATE_MACHINE)
    begin
      unique case (state)
        ST_SW_DISABLED: next_status[6:0] = 7'h40;
        ST_READY: next_status[6:0] = 7'h21;
        ST_SWITCHED_ON: next_status[6:0] = 7'h23;
        ST_OP_ENABLED: next_status[6:0] = 7'h27;
        ST_QUICK_STOP: next_status[6:0] = 7'h07;
        ST_FAULT: next_status[6:0] = 7'h08;
        default: next_status[6:0] = 7'h40;
      endcase
    end
    else
    begin
      next_status[5:0] = in_run ? IN_SW_OP_ENABLED : IN_SW_SWITCHED_ON;
      next_status[SW_FAULT] = pins.fault_active;
    end
    next_status[SW_VOLTAGE] = pins.mains_present;
    next_status[SW_WARNING] = |pins.warn_causes;
    next_status[SW_REMOTE] = (ctrl_src == SRC_STATE_MACHINE) & safe_enable;
    next_status[SW_TARGET] = pins.ref_reached | pins.pfail_zero_hz;
    next_status[SW_LIMIT] = pins.limit_active;
    next_status[13:12] = motion_cfg ? pins.mode_status : 2'h0;
    next_status[SW_WARNING2] = |pins.prewarn_causes;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_word <= '0;
    end
    else
    begin
      status_word <= next_status;
    end
  end

  // Assertions
  dset_forced_a: assert property (@(posedge pclk) disable iff (!presetn)
    dset_sel != DSET_BY_INPUTS |=> active_dset == $past(dset_sel))
    else $error("forced data set not active");

  dset_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    active_dset >= 3'h1 && active_dset <= DSET_MAX)
    else $error("active data set out of range");

  dset_reject_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == OFS_DSET_SEL && pwdata > 32'h4 |=> $stable(dset_sel))
    else $error("out-of-range data set accepted");

  emu_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_src == SRC_EMULATED && (!safe_enable || !ctrl_word[0]) |=> !drive_cmd.run)
    else $error("emulated start without enables");

  vel_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_src != SRC_STATE_MACHINE && !velocity_mode |=> !drive_cmd.run)
    else $error("input start outside velocity mode");

  mains_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    !pins.mains_present |=> !status_word[SW_VOLTAGE] && (ctrl_src == SRC_STATE_MACHINE
      || !drive_cmd.run))
    else $error("start without mains");

  no_mains_sw_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == ST_READY && !pins.mains_present |=> state != ST_SWITCHED_ON)
    else $error("switched on without mains");

  src_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_src != SRC_STATE_MACHINE && !pins.fault_active |=> state == ST_SW_DISABLED)
    else $error("state machine moved outside source 1");

  enable_op_a: assert property (@(posedge pclk) disable iff (!presetn)
    state != ST_OP_ENABLED ##1 state == ST_OP_ENABLED |->
      $past(safe_enable) && ($past(motion_cfg) || $past(pins.start_cw_input)
      || $past(pins.start_ccw_input)))
    else $error("operation enabled without release");

  sto_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_src == SRC_STATE_MACHINE && state == ST_OP_ENABLED && !safe_enable
      && ctrl_word[3:0] == 4'hF
      && !pins.fault_active |=> state == ST_SWITCHED_ON)
    else $error("no fall-back on lost enable");

  remote_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
    status_word[SW_REMOTE] |-> $past(ctrl_src) == SRC_STATE_MACHINE && $past(safe_enable))
    else $error("remote bit without source 1 and enable");

  mode_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(motion_cfg) |-> status_word[13:12] == 2'h0)
    else $error("mode bits outside motion config");

  halt_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    !motion_cfg |=> drive_cmd.motion_bits == 4'h0)
    else $error("motion bits outside motion config");

  fault_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == ST_FAULT && !pins.fault_active && ctrl_src == SRC_STATE_MACHINE
      && fault_reset_edge |=> state == ST_SW_DISABLED)
    else $error("fault reset edge ignored");

endmodule // inv_ctrl

// ===== plc_master.sv
// Remote controller model: issues APB transfers and control-word commands.
// Assumes one clock pclk; the slave answers with pready in its own time.
module plc_master
  import inv_ctrl_pkg::*;
(
  // Clock
  input wire logic pclk,
  // APB master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;

  // Command patterns on control-word bits 0..3 and 7
  localparam logic [31:0] CMD_SHUTDOWN = 32'h0000_0006;
  localparam logic [31:0] CMD_SWITCH_ON = 32'h0000_0007;
  localparam logic [31:0] CMD_ENABLE_OP = 32'h0000_000F;
  localparam logic [31:0] CMD_FAULT_RESET = 32'h0000_0080;

  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // Hold the request until pready is seen high at a rising edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines no longer show the last value
    paddr <= ~a;
    pwdata <= ~d;
  endtask

  // Fault reset needs a 0 to 1 edge on bit 7
  task automatic fault_reset;
    logic [31:0] q;
    logic e;
    xfer(1'b1, OFS_CTRL_WORD, 32'h0, q, e);
    xfer(1'b1, OFS_CTRL_WORD, CMD_FAULT_RESET, q, e);
  endtask
endmodule // plc_master

// ===== tb.sv
// Self-checking bench for the inverter control-source block.
// Assumes plc_master as the APB master and pins driven by the bench.
`define CHK(g, x) begin comparisons++; if ((g) !== (x)) begin err_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, x); end end
module tb
  import inv_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  drive_pins_t pins = '0;
  drive_cmd_t cmd;
  logic [2:0] active_dset;
  int err_count = 0;
  int comparisons = 0;

  always #2.5 pclk = ~pclk;

  inv_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .drive_pins(pins), .drive_cmd(cmd), .active_dset(active_dset));

  plc_master u_plc (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_plc.xfer(1'b1, a, d, q, e);
    repeat (3) @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a);
    u_plc.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic settle;
    repeat (4) @(posedge pclk);
  endtask
  task automatic sw(input logic [15:0] m, input logic [15:0] x);
    rd(OFS_STAT_WORD);
    `CHK(q[15:0] & m, x)
  endtask

  task automatic t_regs;
    rd(OFS_CTRL_SRC);
    `CHK(q, 32'h0)
    rd(OFS_OP_MODE);
    `CHK(q, 32'h2)
    wr(OFS_ACT_DSET, 32'h3);
    rd(OFS_ACT_DSET);
    `CHK(q, 32'h1)
    rd(8'h20);
    `CHK({e, q}, 33'h1_0000_0000)
    $display("test regs done");
  endtask

  task automatic t_dset;
    @(posedge pclk);
    pins.dset_inputs <= 2'h2;
    settle();
    rd(OFS_ACT_DSET);
    `CHK(q, 32'h3)
    wr(OFS_DSET_SEL, 32'h4);
    rd(OFS_ACT_DSET);
    `CHK(q, 32'h4)
    `CHK(active_dset, 3'h4)
    wr(OFS_DSET_SEL, 32'h5);
    rd(OFS_DSET_SEL);
    `CHK(q, 32'h4)
    wr(OFS_DSET_SEL, 32'h0);
    `CHK(active_dset, 3'h3)
    $display("test dset done");
  endtask

  task automatic t_inputs;
    @(posedge pclk);
    pins.torque_off_channel_a <= 1'b1;
    pins.torque_off_channel_b <= 1'b1;
    pins.mains_present <= 1'b1;
    pins.start_cw_input <= 1'b1;
    settle();
    `CHK(cmd.run, 1'b1)
    sw(16'h003F, 16'h0037);
    pins.mains_present <= 1'b0;
    settle();
    `CHK(cmd.run, 1'b0)
    sw(16'h003F, 16'h0023);
    pins.mains_present <= 1'b1;
    wr(OFS_OP_MODE, 32'h3);
    `CHK(cmd.run, 1'b0)
    wr(OFS_OP_MODE, 32'h2);
    pins.start_cw_input <= 1'b0;
    pins.start_ccw_input <= 1'b1;
    settle();
    `CHK({cmd.run, cmd.dir_ccw}, 2'h3)
    $display("test inputs done");
  endtask

  task automatic t_emul;
    @(posedge pclk);
    pins.start_ccw_input <= 1'b0;
    wr(OFS_CTRL_SRC, 32'h2);
    wr(OFS_CTRL_WORD, 32'h3);
    `CHK(cmd.run, 1'b1)
    wr(OFS_CTRL_WORD, 32'h5);
    `CHK({cmd.run, cmd.dir_ccw}, 2'h3)
    pins.torque_off_channel_b <= 1'b0;
    settle();
    `CHK(cmd.run, 1'b0)
    pins.torque_off_channel_b <= 1'b1;
    wr(OFS_CTRL_WORD, 32'h2);
    settle();
    `CHK(cmd.run, 1'b0)
    $display("test emulated done");
  endtask

  task automatic t_sm;
    wr(OFS_CTRL_SRC, 32'h0);
    wr(OFS_CTRL_WORD, u_plc.CMD_ENABLE_OP);
    wr(OFS_CTRL_SRC, 32'h1);
    sw(16'h007F, 16'h0050);
    sw(16'h0200, 16'h0200);
    pins.start_cw_input <= 1'b1;
    wr(OFS_CTRL_WORD, u_plc.CMD_SHUTDOWN);
    sw(16'h007F, 16'h0031);
    pins.mains_present <= 1'b0;
    settle();
    wr(OFS_CTRL_WORD, u_plc.CMD_SWITCH_ON);
    sw(16'h007F, 16'h0021);
    pins.mains_present <= 1'b1;
    settle();
    wr(OFS_CTRL_WORD, u_plc.CMD_SWITCH_ON);
    sw(16'h007F, 16'h0033);
    pins.start_cw_input <= 1'b0;
    settle();
    wr(OFS_CTRL_WORD, u_plc.CMD_ENABLE_OP);
    sw(16'h007F, 16'h0033);
    pins.start_cw_input <= 1'b1;
    settle();
    wr(OFS_CTRL_WORD, u_plc.CMD_ENABLE_OP);
    sw(16'h007F, 16'h0037);
    pins.torque_off_channel_a <= 1'b0;
    settle();
    sw(16'h027F, 16'h0033);
    $display("test state machine done");
  endtask

  task automatic t_motion;
    @(posedge pclk);
    pins.torque_off_channel_a <= 1'b1;
    pins.start_cw_input <= 1'b0;
    pins.mode_status <= 2'h3;
    wr(OFS_CONFIG, 32'h40);
    wr(OFS_CTRL_WORD, 32'hC37F);
    settle();
    sw(16'h007F, 16'h0037);
    `CHK(cmd.motion_bits, 4'hF)
    `CHK(cmd.app_bits, 6'h21)
    sw(16'h3000, 16'h3000);
    wr(OFS_CONFIG, 32'h0);
    `CHK(cmd.motion_bits, 4'h0)
    sw(16'h3000, 16'h0000);
    wr(OFS_CTRL_WORD, 32'h0B);
    `CHK(cmd.quick_stop, 1'b1)
    sw(16'h007F, 16'h0017);
    pins.fault_active <= 1'b1;
    settle();
    sw(16'h004F, 16'h0008);
    pins.fault_active <= 1'b0;
    settle();
    u_plc.fault_reset();
    settle();
    sw(16'h004F, 16'h0040);
    $display("test motion and fault done");
  endtask

  task automatic t_flags;
    @(posedge pclk);
    pins.warn_causes <= 8'h81;
    pins.prewarn_causes <= 4'h2;
    pins.ref_reached <= 1'b1;
    pins.limit_active <= 1'b1;
    settle();
    sw(16'h0080, 16'h0080);
    sw(16'h0400, 16'h0400);
    sw(16'h0800, 16'h0800);
    sw(16'h8000, 16'h8000);
    rd(OFS_WARN_STAT);
    `CHK(q, 32'h0000_0281)
    pins.ref_reached <= 1'b0;
    pins.pfail_zero_hz <= 1'b1;
    settle();
    sw(16'h0400, 16'h0400);
    pins.pfail_zero_hz <= 1'b0;
    pins.warn_causes <= 8'h00;
    pins.prewarn_causes <= 4'h0;
    pins.limit_active <= 1'b0;
    settle();
    sw(16'h8C80, 16'h0000);
    $display("test flags done");
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #100us;
    err_count++;
    complete_run();
  end

  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_dset();
    t_inputs();
    t_emul();
    t_sm();
    t_motion();
    t_flags();
    complete_run();
  end
endmodule // tb
